// ==== verilog/sbm_supply_monitor.sv ====
// Supply brownout monitor: control register, low-supply flag, interrupts.
// Assumes an analog comparator outside, asynchronous to clk_sys, and a
// register master that keeps the single-cycle strobe protocol.
`timescale 1ns/1ns

// Functional notes
// - Comparator low sets low-supply flag while monitor enabled
// - Write one clears flag once supply recovered
// - Clear accepted first cycle after recovery
// - Bit 3 mirrors comparator, read only
// - Bit 2 selects trip level
// - Bit 1 enables the monitor
// - Flag raises interrupt when enabled
// - No new low interrupt until flag cleared
// - Bits 15 to 4 read zero
module sbm_supply_monitor (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  // Register port
  input  wire sbm_pkg::sbm_bus_req_t      bus_req,
  output logic [sbm_pkg::DATA_W-1:0]      rdata,
  // Analog comparator side
  input  wire logic                       cmp_raw,
  output sbm_pkg::sbm_ana_ctl_t           ana_ctl,
  // Interrupt side
  output logic                            low_supply_flag,
  output logic                            irq
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser
  logic cmp_meta_r;
  logic cmp_sync_r;
  logic cmp_prev_r;

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cmp_meta_r <= 1'b1;
      cmp_sync_r <= 1'b1;
      cmp_prev_r <= 1'b1;
    end else begin
      cmp_meta_r <= cmp_raw;
      cmp_sync_r <= cmp_meta_r;
      cmp_prev_r <= cmp_sync_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic                         flag_r;
  logic                         flag_nxt;
  logic                         en_r;
  logic                         en_nxt;
  logic                         trip_r;
  logic                         trip_nxt;
  logic [sbm_pkg::INT_W-1:0]    ist_r;
  logic [sbm_pkg::INT_W-1:0]    ist_nxt;
  logic [sbm_pkg::INT_W-1:0]    imsk_r;
  logic [sbm_pkg::INT_W-1:0]    imsk_nxt;
  logic [sbm_pkg::DATA_W-1:0]   rdata_r;
  logic [sbm_pkg::DATA_W-1:0]   rdata_nxt;
  logic                         irq_r;
  logic                         irq_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  wire sel_ctl  = (bus_req.addr == sbm_pkg::CTL_ADDR);
  wire sel_ist  = (bus_req.addr == sbm_pkg::IST_ADDR);
  wire sel_imsk = (bus_req.addr == sbm_pkg::IMSK_ADDR);
  wire wr_ctl   = bus_req.wr && sel_ctl;
  wire wr_ist   = bus_req.wr && sel_ist;
  wire wr_imsk  = bus_req.wr && sel_imsk;

  ////////////////////////////////////////////////////////////////////////
  // Supply state
  // Powered-down monitor reads as supply above trip
  wire cmp_view  = cmp_sync_r || !en_r;
  wire supply_lo = en_r && !cmp_sync_r;
  wire recovered = cmp_sync_r && !cmp_prev_r && en_r;

  // Clear needs recovered supply, no wait counter
  wire flag_clr  = wr_ctl && bus_req.wdata[sbm_pkg::CTL_FLAG_BIT]
                   && cmp_sync_r;

  assign flag_nxt = supply_lo ? 1'b1 :
                    flag_clr  ? 1'b0 : flag_r;
  assign en_nxt   = wr_ctl ? bus_req.wdata[sbm_pkg::CTL_EN_BIT] : en_r;
  assign trip_nxt = wr_ctl ? bus_req.wdata[sbm_pkg::CTL_TRIP_BIT] : trip_r;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask
  // Onset only on a flag rising edge, so a held low raises nothing new
  wire                      low_onset = supply_lo && !flag_r;
  wire [sbm_pkg::INT_W-1:0] ist_set   = {recovered, low_onset};
  wire [sbm_pkg::INT_W-1:0] ist_clr   = wr_ist ? bus_req.wdata[sbm_pkg::INT_W-1:0]
                                               : {sbm_pkg::INT_W{1'b0}};

  // Set wins over clear
  assign ist_nxt  = ist_set | (ist_r & ~ist_clr);
  assign imsk_nxt = wr_imsk ? bus_req.wdata[sbm_pkg::INT_W-1:0] : imsk_r;
  assign irq_nxt  = |(ist_r & imsk_r);

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [sbm_pkg::DATA_W-1:0] ctl_view = {12'h000, cmp_view, trip_r, en_r, flag_r};
  wire [sbm_pkg::DATA_W-1:0] ist_view = {14'h0, ist_r};
  wire [sbm_pkg::DATA_W-1:0] msk_view = {14'h0, imsk_r};

  assign rdata_nxt = !bus_req.rd ? 16'h0000 :
                     sel_ctl     ? ctl_view :
                     sel_ist     ? ist_view :
                     sel_imsk    ? msk_view : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // State flops
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      flag_r  <= sbm_pkg::CTL_RST[sbm_pkg::CTL_FLAG_BIT];
      en_r    <= sbm_pkg::CTL_RST[sbm_pkg::CTL_EN_BIT];
      trip_r  <= sbm_pkg::CTL_RST[sbm_pkg::CTL_TRIP_BIT];
      ist_r   <= sbm_pkg::IST_RST;
      imsk_r  <= sbm_pkg::IMSK_RST;
      rdata_r <= 16'h0000;
      irq_r   <= 1'b0;
    end else begin
      flag_r  <= flag_nxt;
      en_r    <= en_nxt;
      trip_r  <= trip_nxt;
      ist_r   <= ist_nxt;
      imsk_r  <= imsk_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata            = rdata_r;
  assign ana_ctl.enable   = en_r;
  assign ana_ctl.trip_sel = trip_r;
  assign low_supply_flag  = flag_r;
  assign irq              = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_sync_b);

  sequence s_low_held;
    en_r && !cmp_sync_r;
  endsequence

  sequence s_recover;
    $rose(cmp_sync_r) && en_r;
  endsequence

  sequence s_clear_wr;
    bus_req.wr && sel_ctl && bus_req.wdata[sbm_pkg::CTL_FLAG_BIT];
  endsequence

  property p_flag_set;
    s_low_held |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set while supply low");

  property p_flag_holds_low;
    s_low_held ##0 s_clear_wr |=> flag_r;
  endproperty
  a_flag_holds_low: assert property (p_flag_holds_low)
    else $error("flag cleared while supply still low");

  property p_write_zero;
    flag_r && wr_ctl && !bus_req.wdata[sbm_pkg::CTL_FLAG_BIT] |=> flag_r;
  endproperty
  a_write_zero: assert property (p_write_zero)
    else $error("write of zero changed the flag");

  property p_clear_now;
    s_recover ##0 s_clear_wr |=> !flag_r;
  endproperty
  a_clear_now: assert property (p_clear_now)
    else $error("clear not taken right after recovery");

  property p_cmp_bit;
    bus_req.rd && sel_ctl |=>
      rdata[sbm_pkg::CTL_CMP_BIT] == ($past(cmp_sync_r) || !$past(en_r));
  endproperty
  a_cmp_bit: assert property (p_cmp_bit)
    else $error("comparator bit does not follow comparator");

  property p_trip;
    wr_ctl |=> ana_ctl.trip_sel == $past(bus_req.wdata[sbm_pkg::CTL_TRIP_BIT]);
  endproperty
  a_trip: assert property (p_trip)
    else $error("trip select not taken from write");

  property p_enable;
    wr_ctl |=> ana_ctl.enable == $past(bus_req.wdata[sbm_pkg::CTL_EN_BIT])
           ##1 ana_ctl.enable == $past(en_nxt);
  endproperty
  a_enable: assert property (p_enable)
    else $error("monitor enable not taken from write");

  property p_irq;
    en_r && !cmp_sync_r && !flag_r && imsk_r[sbm_pkg::INT_LOW_BIT]
      && !wr_imsk |=> ##1 irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked low supply raised no interrupt");

  property p_irq_quiet;
    (ist_r & imsk_r) == 2'h0 |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt high with nothing pending");

  property p_no_repeat;
    flag_r && !cmp_sync_r && wr_ist && bus_req.wdata[sbm_pkg::INT_LOW_BIT]
      ##1 !cmp_sync_r [*2] |-> !ist_r[sbm_pkg::INT_LOW_BIT];
  endproperty
  a_no_repeat: assert property (p_no_repeat)
    else $error("low supply event repeated before recovery");

  property p_reserved;
    bus_req.rd && sel_ctl |=> rdata[sbm_pkg::CTL_RSV_MSB:sbm_pkg::CTL_RSV_LSB] == 12'h000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits read nonzero");

  property p_sync;
    ##2 1'b1 |-> cmp_sync_r == $past(cmp_raw, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("comparator not delayed by two flops");

  property p_read_once;
    !bus_req.rd |=> rdata == 16'h0000;
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("read data outside its cycle");

  property p_flag_only_cleared;
    flag_r && !(wr_ctl && bus_req.wdata[sbm_pkg::CTL_FLAG_BIT] && cmp_sync_r) |=> flag_r;
  endproperty
  a_flag_only_cleared: assert property (p_flag_only_cleared)
    else $error("flag fell without a qualified clear");

  property p_flag_read;
    bus_req.rd && sel_ctl |=> rdata[sbm_pkg::CTL_FLAG_BIT] == $past(flag_r);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flag bit reads a wrong value");

  property p_en_read;
    bus_req.rd && sel_ctl |=> rdata[sbm_pkg::CTL_EN_BIT] == $past(en_r);
  endproperty
  a_en_read: assert property (p_en_read)
    else $error("enable bit reads a wrong value");

  property p_trip_read;
    bus_req.rd && sel_ctl |=> rdata[sbm_pkg::CTL_TRIP_BIT] == $past(trip_r);
  endproperty
  a_trip_read: assert property (p_trip_read)
    else $error("trip bit reads a wrong value");

  property p_ana_hold;
    !wr_ctl |=> $stable(ana_ctl.enable) && $stable(ana_ctl.trip_sel);
  endproperty
  a_ana_hold: assert property (p_ana_hold)
    else $error("analog control changed without a write");

  sequence s_onset;
    s_low_held ##0 !flag_r;
  endsequence

  property p_onset;
    s_onset |=> ist_r[sbm_pkg::INT_LOW_BIT];
  endproperty
  a_onset: assert property (p_onset)
    else $error("low supply onset not recorded");

  property p_no_new_onset;
    flag_r && !ist_r[sbm_pkg::INT_LOW_BIT] |=> !ist_r[sbm_pkg::INT_LOW_BIT];
  endproperty
  a_no_new_onset: assert property (p_no_new_onset)
    else $error("new low event while flag still set");

  property p_recover;
    s_recover |=> ist_r[sbm_pkg::INT_REC_BIT];
  endproperty
  a_recover: assert property (p_recover)
    else $error("recovery event not recorded");

  property p_irq_on;
    (ist_r & imsk_r) != 2'h0 |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("pending unmasked event raised no interrupt");

  property p_off_no_set;
    !en_r && !flag_r |=> !flag_r;
  endproperty
  a_off_no_set: assert property (p_off_no_set)
    else $error("flag set while monitor disabled");

  property p_mask_wr;
    wr_imsk |=> imsk_r == $past(bus_req.wdata[sbm_pkg::INT_W-1:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr)
    else $error("mask not taken from write");

  property p_ist_clr;
    wr_ist && bus_req.wdata[sbm_pkg::INT_LOW_BIT] && !low_onset |=> !ist_r[sbm_pkg::INT_LOW_BIT];
  endproperty
  a_ist_clr: assert property (p_ist_clr)
    else $error("status bit not cleared by write of one");

  property p_sync_first;
    rst_sync_b |=> cmp_meta_r == $past(cmp_raw);
  endproperty
  a_sync_first: assert property (p_sync_first)
    else $error("first synchroniser stage missed the comparator");

  property p_unmapped;
    bus_req.rd && !sel_ctl && !sel_ist && !sel_imsk |=> rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");

  property p_ist_rsv;
    bus_req.rd && sel_ist |=> rdata[sbm_pkg::DATA_W-1:sbm_pkg::INT_W] == 14'h0;
  endproperty
  a_ist_rsv: assert property (p_ist_rsv)
    else $error("unused status bits read nonzero");

endmodule

// ==== pkg/sbm_pkg.sv ====
// Package for the supply brownout monitor: register map, fields, carriers.
// Assumes a plain single-cycle register port and one 20 MHz system clock.
package sbm_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned INT_W  = 2;

  ////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [ADDR_W-1:0] CTL_ADDR  = 32'hFFFF0440;
  localparam logic [ADDR_W-1:0] IST_ADDR  = 32'hFFFF0444;
  localparam logic [ADDR_W-1:0] IMSK_ADDR = 32'hFFFF0448;

  ////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned CTL_FLAG_BIT = 0;
  localparam int unsigned CTL_EN_BIT   = 1;
  localparam int unsigned CTL_TRIP_BIT = 2;
  localparam int unsigned CTL_CMP_BIT  = 3;
  localparam int unsigned CTL_RSV_LSB  = 4;
  localparam int unsigned CTL_RSV_MSB  = 15;
  localparam logic [DATA_W-1:0] CTL_RST = 16'h0008;

  // Interrupt status and mask fields
  localparam int unsigned INT_LOW_BIT = 0;
  localparam int unsigned INT_REC_BIT = 1;
  localparam logic [INT_W-1:0] IST_RST  = 2'h0;
  localparam logic [INT_W-1:0] IMSK_RST = 2'h0;

  // Trip level encodings
  localparam logic TRIP_LOW  = 1'b0;
  localparam logic TRIP_HIGH = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sbm_bus_req_t;

  typedef struct packed {
    logic enable;
    logic trip_sel;
  } sbm_ana_ctl_t;

endpackage

// ==== verif/sbm_far_side.sv ====
// Far side model: analog supply comparator and core interrupt controller.
// Assumes the bench gives the supply level in millivolts.
`timescale 1ns/1ns
module sbm_far_side #(
  parameter int LO_MV = 2790,
  parameter int HI_MV = 3070
) (
  // Analog side
  input  wire sbm_pkg::sbm_ana_ctl_t ana_ctl,
  input  wire logic [15:0]           supply_mv,
  output logic                       cmp_raw,
  // Interrupt controller side
  input  wire logic                  low_supply_flag,
  input  wire logic [1:0]            irq_en,
  output logic [1:0]                 core_irq
);
  // Powered down reads as above trip
  assign cmp_raw  = !ana_ctl.enable || supply_mv >= (ana_ctl.trip_sel ? HI_MV : LO_MV);
  // Normal and fast enables gate the flag
  assign core_irq = {2{low_supply_flag}} & irq_en;
endmodule

// ==== verif/test_sbm_supply_monitor.sv ====
// Self-checking bench for the supply brownout monitor.
// Assumes the far side model and the design package.
`timescale 1ns/1ns
module test_sbm_supply_monitor;
  logic                  clk_sys   = 1'b0;
  logic                  rst_b     = 1'b0;
  sbm_pkg::sbm_bus_req_t bus_req   = '0;
  logic [15:0]           supply_mv = 16'd3300;
  logic [1:0]            irq_en    = 2'h0;
  logic [15:0]           rdata;
  logic [15:0]           v;
  logic                  cmp_raw;
  logic                  low_supply_flag;
  logic                  irq;
  logic [1:0]            core_irq;
  sbm_pkg::sbm_ana_ctl_t ana_ctl;
  int                    n_errors   = 0;
  int                    num_checks = 0;
  bit                    en, tp, fl;
  bit                    cm = 1'b1;
  bit [1:0]              st, msk;

  always #25 clk_sys = ~clk_sys;

  sbm_supply_monitor DUT (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
    .cmp_raw(cmp_raw), .ana_ctl(ana_ctl), .low_supply_flag(low_supply_flag), .irq(irq));
  sbm_far_side far (.ana_ctl(ana_ctl), .supply_mv(supply_mv), .cmp_raw(cmp_raw),
    .low_supply_flag(low_supply_flag), .irq_en(irq_en), .core_irq(core_irq));

  ////////////////////////////////////////
  // Model and checks
  function automatic void upd();
    bit c = !en || supply_mv >= (tp ? 3070 : 2790);
    if (en && c && !cm) st[1] = 1'b1;
    cm = c;
    if (!cm) begin
      if (!fl) st[0] = 1'b1;
      fl = 1'b1;
    end
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////
  // Register port
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    if (a == sbm_pkg::CTL_ADDR) begin
      if (d[0] && cm) fl = 1'b0;
      en = d[1];
      tp = d[2];
    end
    if (a == sbm_pkg::IST_ADDR) st &= ~d[1:0];
    if (a == sbm_pkg::IMSK_ADDR) msk = d[1:0];
    upd();
  endtask

  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(negedge clk_sys);
    chk(rdata, exp);
  endtask

  task automatic sup(input int mv, input int n);
    @(posedge clk_sys);
    supply_mv <= 16'(mv);
    @(negedge clk_sys);
    upd();
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk_all;
    repeat (5) @(posedge clk_sys);
    irq_en <= 2'($urandom);
    @(negedge clk_sys);
    chk({14'h0, ana_ctl}, {14'h0, en, tp});
    chk({14'h0, low_supply_flag, irq}, {14'h0, fl, |(st & msk)});
    chk({14'h0, core_irq}, {14'h0, {2{fl}} & irq_en});
    rd(sbm_pkg::CTL_ADDR, {12'h0, cm, tp, en, fl});
    rd(sbm_pkg::IST_ADDR, {14'h0, st});
  endtask

  ////////////////////////////////////////
  // Scenarios
  initial begin
    v = 16'($urandom(64144));
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk_all;
    wr(32'hFFFF044C, v);
    rd(32'hFFFF044C, 16'h0000);
    sup(2000 + $urandom % 700, 0);
    chk_all;
    wr(sbm_pkg::IMSK_ADDR, 16'h0003);
    wr(sbm_pkg::CTL_ADDR, {12'($urandom), 4'b0110});
    chk_all;
    wr(sbm_pkg::CTL_ADDR, 16'h0007);
    wr(sbm_pkg::IST_ADDR, 16'h0001);
    chk_all;
    sup(3100 + $urandom % 200, 1);
    wr(sbm_pkg::CTL_ADDR, 16'h0007);
    chk_all;
    sup(2800 + $urandom % 260, 0);
    wr(sbm_pkg::CTL_ADDR, 16'h0006);
    chk_all;
    wr(sbm_pkg::CTL_ADDR, 16'h0003);
    chk_all;
    for (int i = 0; i < 12; i++) begin
      sup(2000 + $urandom % 1400, 1);
      wr(sbm_pkg::CTL_ADDR, 16'($urandom) | 16'h0002);
      wr(sbm_pkg::IMSK_ADDR, 16'($urandom));
      chk_all;
      wr(sbm_pkg::IST_ADDR, 16'($urandom));
    end
    print_verdict;
  end
endmodule
